/* File: cmo_consts.svh */
// register offsets, field positions, reset values and timing counts
`ifndef CMO_CONSTS_SVH
`define CMO_CONSTS_SVH
`define CMO_A_CTRL    4'h0
`define CMO_A_STATUS  4'h1
`define CMO_A_PAGE    4'h2
`define CMO_A_HPOBJ   4'h3
`define CMO_A_TCON    4'h4
`define CMO_A_TIMER   4'h5
`define CMO_A_TTCAP   4'h6
`define CMO_A_CFG     4'h8
`define CMO_A_FLAGS   4'h9
`define CMO_A_TAG     4'hA
`define CMO_A_MASK    4'hB
`define CMO_A_MSG     4'hC
`define CMO_A_STAMP   4'hD
// ctrl bits
`define CMO_C_ENA     0
`define CMO_C_TTC     1
`define CMO_C_SYNC    2
`define CMO_C_TXIE    3
`define CMO_C_RXIE    4
`define CMO_C_ERIE    5
// status bits
`define CMO_S_ENABLED_FLAG    0
`define CMO_S_OVR     1
`define CMO_S_BSET    2
// flags bits
`define CMO_F_RECEIVE_DONE_FLAG    0
`define CMO_F_TRANSMIT_DONE_FLAG    1
`define CMO_PAGE_RST  8'h00
`define CMO_TCON_RST  8'h00
`define CMO_NONE_PAGE 8'hF0
`define CMO_DIV_IO    3'h7
`endif

/* File: cmo_pkg.sv */
// types of the message-object manager
package cmo_pkg;
   typedef enum logic [1:0] {CMO_OFF, CMO_TX, CMO_RX, CMO_FB} cmo_mode_t;
   // frame header as seen by acceptance filter: {ide, rb, rtr, id}
   typedef struct packed {
      logic        valid;
      logic [31:0] hdr;
   } cmo_rx_hdr_t;
   typedef struct packed {
      logic            valid;
      logic            err;
      logic [3:0]      dlc;
      logic [7:0][7:0] data;
   } cmo_rx_end_t;
   typedef struct packed {
      logic            valid;
      logic [31:0]     hdr;
      logic [3:0]      dlc;
      logic [7:0][7:0] data;
      logic            single;
   } cmo_tx_req_t;
   typedef struct packed {
      cmo_mode_t       cfg;
      logic            reply_valid_bit;
      logic            armed;
      logic            reply;
      logic            fb_got;
      logic            rewr;
      logic            receive_done_flag;
      logic            transmit_done_flag;
      logic [3:0]      dlc;
      logic [31:0]     tag;
      logic [31:0]     mask;
      logic [15:0]     stamp;
      logic [7:0][7:0] data;
   } cmo_desc_t;
   typedef struct packed {
      cmo_desc_t [14:0] d;
      logic [5:0]       ctrl;
      logic             enabled_flag;
      logic             ovr;
      logic             bset;
      logic             fb_all;
      logic [3:0]       page;
      logic             auto_increment_disable_dis;
      logic [2:0]       index;
      logic [7:0]       hpobj;
      logic [7:0]       tcon;
      logic [2:0]       div;
      logic [7:0]       pre;
      logic [15:0]      timer;
      logic [15:0]      ttcap;
      logic             hit;
      logic [3:0]       rx_idx;
      logic             tx_busy;
      logic [3:0]       tx_idx;
      logic [31:0]      rdata;
   } cmo_state_t;
endpackage

/* File: cmo_manager.sv */
// message-object manager: descriptors, filter, paging, data buffers, stamp timer
//
// The address map and the strobed register port were decided locally.
`timescale 1ns/1ps
`include "cmo_consts.svh"

module cmo_manager #(
   parameter int N_OBJ = 15
)(
   // clock and reset
   input  wire logic               i_core_clk,
   input  wire logic               i_rstn,
   // register port
   input  wire logic [3:0]         i_addr,
   input  wire logic [31:0]        i_wdata,
   input  wire logic               i_wr,
   input  wire logic               i_rd,
   output logic      [31:0]        o_rdata,
   // frame engine
   input  wire cmo_pkg::cmo_rx_hdr_t i_rx_hdr,
   input  wire cmo_pkg::cmo_rx_end_t i_rx_end,
   input  wire logic               i_sof,
   input  wire logic               i_eof,
   input  wire logic               i_tx_done,
   input  wire logic               i_tx_err,
   output cmo_pkg::cmo_tx_req_t    o_tx,
   // status
   output logic                    o_enabled,
   output logic                    o_timer_ovf
);

   if (N_OBJ != 15) $error("cmo_manager serves exactly 15 descriptors");

   cmo_pkg::cmo_state_t s_q;
   cmo_pkg::cmo_state_t s_d;

   logic        pv;
   logic        m_found;
   logic [3:0]  m_idx;
   logic        t_found;
   logic [3:0]  t_idx;
   logic        h_found;
   logic [3:0]  h_idx;
   logic        fb_any;
   logic        fb_done;
   logic        fb_rewr;
   logic        tick;
   logic        remote;

   //------------------------------------------------------------
   // priority scans
   //------------------------------------------------------------
   always_comb
   begin
      m_found = 1'b0;
      m_idx   = 4'h0;
      t_found = 1'b0;
      t_idx   = 4'h0;
      h_found = 1'b0;
      h_idx   = 4'h0;
      fb_any  = 1'b0;
      fb_done = 1'b1;
      fb_rewr = 1'b1;
      // descending walk: last hit is the lowest number
      for (int i = 14; i >= 0; i--)
      begin
         if (s_q.d[i].armed && !s_q.d[i].reply &&
             (s_q.d[i].cfg == cmo_pkg::CMO_RX || s_q.d[i].cfg == cmo_pkg::CMO_FB) &&
             (((i_rx_hdr.hdr ^ s_q.d[i].tag) & s_q.d[i].mask) == 32'h0000_0000))
         begin
            m_found = 1'b1;
            m_idx   = 4'(i);
         end
         if (s_q.d[i].armed &&
             (s_q.d[i].cfg == cmo_pkg::CMO_TX || s_q.d[i].reply))
         begin
            t_found = 1'b1;
            t_idx   = 4'(i);
         end
         if ((s_q.d[i].receive_done_flag && s_q.ctrl[`CMO_C_RXIE]) ||
             (s_q.d[i].transmit_done_flag && s_q.ctrl[`CMO_C_TXIE]))
         begin
            h_found = 1'b1;
            h_idx   = 4'(i);
         end
         if (s_q.d[i].cfg == cmo_pkg::CMO_FB)
         begin
            fb_any  = 1'b1;
            fb_done = fb_done & s_q.d[i].fb_got;
            fb_rewr = fb_rewr & s_q.d[i].rewr;
         end
      end
      fb_done = fb_done & fb_any;
   end

   assign pv     = (s_q.page != 4'hF);
   assign remote = s_q.d[s_q.rx_idx].tag[29];
   assign tick   = s_q.enabled_flag && s_q.div == 3'h0 && s_q.pre == 8'h00;

   //------------------------------------------------------------
   // next state
   //------------------------------------------------------------
   always_comb
   begin
      s_d       = s_q;
      s_d.rdata = 32'h0000_0000;
      s_d.enabled_flag  = s_q.ctrl[`CMO_C_ENA];

      // software writes; hardware sets below override clears
      if (i_wr)
      begin
         unique case (i_addr)
            `CMO_A_CTRL:   s_d.ctrl = i_wdata[5:0];
            `CMO_A_STATUS:
            begin
               if (i_wdata[`CMO_S_OVR])
                  s_d.ovr = 1'b0;
               if (i_wdata[`CMO_S_BSET] && fb_rewr)
                  s_d.bset = 1'b0;
            end
            `CMO_A_PAGE:
            begin
               s_d.page     = i_wdata[7:4];
               s_d.auto_increment_disable_dis = i_wdata[3];
               s_d.index    = i_wdata[2:0];
            end
            `CMO_A_TCON:   s_d.tcon = i_wdata[7:0];
            `CMO_A_CFG:
               if (pv)
               begin
                  s_d.d[s_q.page].cfg    = cmo_pkg::cmo_mode_t'(i_wdata[7:6]);
                  s_d.d[s_q.page].reply_valid_bit   = i_wdata[5];
                  s_d.d[s_q.page].dlc    = i_wdata[3:0];
                  s_d.d[s_q.page].armed  = (i_wdata[7:6] != 2'b00);
                  s_d.d[s_q.page].reply  = 1'b0;
                  s_d.d[s_q.page].fb_got = 1'b0;
                  s_d.d[s_q.page].rewr   = 1'b1;
               end
            `CMO_A_FLAGS:
               if (pv)
               begin
                  s_d.d[s_q.page].receive_done_flag = s_q.d[s_q.page].receive_done_flag & i_wdata[`CMO_F_RECEIVE_DONE_FLAG];
                  s_d.d[s_q.page].transmit_done_flag = s_q.d[s_q.page].transmit_done_flag & i_wdata[`CMO_F_TRANSMIT_DONE_FLAG];
               end
            `CMO_A_TAG:    if (pv) s_d.d[s_q.page].tag  = i_wdata;
            `CMO_A_MASK:   if (pv) s_d.d[s_q.page].mask = i_wdata;
            `CMO_A_MSG:    if (pv) s_d.d[s_q.page].data[s_q.index] = i_wdata[7:0];
            default: ;
         endcase
      end

      if (i_rd)
      begin
         unique case (i_addr)
            `CMO_A_CTRL:   s_d.rdata = {26'h0, s_q.ctrl};
            `CMO_A_STATUS: s_d.rdata = {29'h0, s_q.bset, s_q.ovr, s_q.enabled_flag};
            `CMO_A_PAGE:   s_d.rdata = {24'h0, s_q.page, s_q.auto_increment_disable_dis, s_q.index};
            `CMO_A_HPOBJ:  s_d.rdata = {24'h0, s_q.hpobj};
            `CMO_A_TCON:   s_d.rdata = {24'h0, s_q.tcon};
            `CMO_A_TIMER:  s_d.rdata = {16'h0, s_q.timer};
            `CMO_A_TTCAP:  s_d.rdata = {16'h0, s_q.ttcap};
            `CMO_A_CFG:
               if (pv)
                  s_d.rdata = {24'h0, s_q.d[s_q.page].cfg, s_q.d[s_q.page].reply_valid_bit,
                               1'b0, s_q.d[s_q.page].dlc};
            `CMO_A_FLAGS:
               if (pv)
                  s_d.rdata = {30'h0, s_q.d[s_q.page].transmit_done_flag, s_q.d[s_q.page].receive_done_flag};
            `CMO_A_TAG:    if (pv) s_d.rdata = s_q.d[s_q.page].tag;
            `CMO_A_MASK:   if (pv) s_d.rdata = s_q.d[s_q.page].mask;
            `CMO_A_MSG:    if (pv) s_d.rdata = {24'h0, s_q.d[s_q.page].data[s_q.index]};
            `CMO_A_STAMP:  if (pv) s_d.rdata = {16'h0, s_q.d[s_q.page].stamp};
            default: ;
         endcase
      end

      // every message access steps the byte pointer unless auto-increment is disabled, 3 bits wrap 7 to 0
      if ((i_wr || i_rd) && i_addr == `CMO_A_MSG && !s_q.auto_increment_disable_dis)
         s_d.index = s_q.index + 3'h1;

      //---------------------------------------------------------
      // stamp timer
      //---------------------------------------------------------
      if (!s_q.enabled_flag)
      begin
         s_d.div   = `CMO_DIV_IO;
         s_d.pre   = s_q.tcon;
         s_d.timer = 16'h0000;
      end
      else
      begin
         s_d.div = s_q.div - 3'h1;
         if (s_q.div == 3'h0)
            s_d.pre = (s_q.pre == 8'h00) ? s_q.tcon : s_q.pre - 8'h01;
         if (tick)
         begin
            s_d.timer = s_q.timer + 16'h0001;
            if (s_q.timer == 16'hFFFF)
               s_d.ovr = 1'b1;
         end
      end
      if (s_q.ctrl[`CMO_C_TTC] &&
          (s_q.ctrl[`CMO_C_SYNC] ? i_eof : i_sof))
         s_d.ttcap = s_q.timer;

      //---------------------------------------------------------
      // receive path
      //---------------------------------------------------------
      if (s_q.enabled_flag && i_rx_hdr.valid)
      begin
         s_d.hit = m_found;
         s_d.rx_idx = m_idx;
         if (m_found)
            s_d.d[m_idx].tag = i_rx_hdr.hdr;
      end
      if (i_rx_end.valid || i_rx_end.err)
         s_d.hit = 1'b0;
      if (i_rx_end.valid && s_q.hit)
      begin
         s_d.d[s_q.rx_idx].dlc = i_rx_end.dlc;
         if (remote && s_q.d[s_q.rx_idx].reply_valid_bit && s_q.d[s_q.rx_idx].cfg == cmo_pkg::CMO_RX)
         begin
            s_d.d[s_q.rx_idx].tag[29] = 1'b0;
            s_d.d[s_q.rx_idx].reply_valid_bit    = 1'b0;
            s_d.d[s_q.rx_idx].reply   = 1'b1;
         end
         else
         begin
            if (!remote)
               s_d.d[s_q.rx_idx].data = i_rx_end.data;
            s_d.d[s_q.rx_idx].receive_done_flag  = 1'b1;
            s_d.d[s_q.rx_idx].stamp = s_q.timer;
            s_d.d[s_q.rx_idx].armed = 1'b0;
            if (s_q.d[s_q.rx_idx].cfg == cmo_pkg::CMO_FB)
            begin
               s_d.d[s_q.rx_idx].fb_got = 1'b1;
               s_d.d[s_q.rx_idx].rewr   = 1'b0;
            end
         end
      end

      // buffer set completes on the rising edge of all-received
      s_d.fb_all = fb_done;
      if (fb_done && !s_q.fb_all)
         s_d.bset = 1'b1;

      //---------------------------------------------------------
      // transmit path
      //---------------------------------------------------------
      if (s_q.tx_busy && i_tx_done)
      begin
         s_d.tx_busy = 1'b0;
         s_d.d[s_q.tx_idx].transmit_done_flag  = 1'b1;
         s_d.d[s_q.tx_idx].stamp = s_q.timer;
         s_d.d[s_q.tx_idx].armed = 1'b0;
         s_d.d[s_q.tx_idx].reply = 1'b0;
      end
      else if (s_q.tx_busy && i_tx_err)
      begin
         s_d.tx_busy = 1'b0;
         if (s_q.ctrl[`CMO_C_TTC])
            s_d.d[s_q.tx_idx].armed = 1'b0;
      end
      else if (!s_q.tx_busy && s_q.enabled_flag && t_found)
      begin
         s_d.tx_busy = 1'b1;
         s_d.tx_idx  = t_idx;
      end

      // top object follows flags only while an enable is on
      if (s_q.ctrl[`CMO_C_TXIE] || s_q.ctrl[`CMO_C_RXIE] || s_q.ctrl[`CMO_C_ERIE])
         s_d.hpobj = h_found ? {h_idx, 4'h0} : `CMO_NONE_PAGE;
   end

   //------------------------------------------------------------
   // state register
   //------------------------------------------------------------
   always_ff @(posedge i_core_clk)
   begin
      if (!i_rstn)
      begin
         s_q       <= '0;
         {s_q.page, s_q.auto_increment_disable_dis, s_q.index} <= `CMO_PAGE_RST;
         s_q.tcon  <= `CMO_TCON_RST;
         s_q.hpobj <= `CMO_NONE_PAGE;
         s_q.div   <= `CMO_DIV_IO;
      end
      else
         s_q <= s_d;
   end

   // outputs
   assign o_rdata       = s_q.rdata;
   assign o_enabled     = s_q.enabled_flag;
   assign o_timer_ovf   = s_q.ovr;
   assign o_tx.valid    = s_q.tx_busy;
   assign o_tx.hdr      = s_q.d[s_q.tx_idx].reply ?
                          {s_q.d[s_q.tx_idx].tag[31:30], 1'b0, s_q.d[s_q.tx_idx].tag[28:0]} :
                          s_q.d[s_q.tx_idx].tag;
   assign o_tx.dlc      = s_q.d[s_q.tx_idx].dlc;
   assign o_tx.data     = s_q.d[s_q.tx_idx].data;
   assign o_tx.single   = s_q.ctrl[`CMO_C_TTC];

   //------------------------------------------------------------
   // checks
   //------------------------------------------------------------
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rstn);

   sequence s_txdone;
      s_q.tx_busy && i_tx_done;
   endsequence
   sequence s_rxdone;
      i_rx_end.valid && s_q.hit && !(remote && s_q.d[s_q.rx_idx].reply_valid_bit);
   endsequence

   property p_transmit_done_flag;
      s_txdone |=> s_q.d[$past(s_q.tx_idx)].transmit_done_flag && !s_q.tx_busy;
   endproperty
   a_transmit_done_flag: assert property (p_transmit_done_flag) else $error("tx done flag not set");
   property p_receive_done_flag;
      s_rxdone |=> s_q.d[$past(s_q.rx_idx)].receive_done_flag;
   endproperty
   a_receive_done_flag: assert property (p_receive_done_flag) else $error("rx done flag not set");
   property p_stamp;
      s_txdone |=> s_q.d[$past(s_q.tx_idx)].stamp == $past(s_q.timer);
   endproperty
   a_stamp: assert property (p_stamp) else $error("stamp missed");
   property p_nohit;
      (s_q.enabled_flag && i_rx_hdr.valid && !m_found) |=> !s_q.hit;
   endproperty
   a_nohit: assert property (p_nohit) else $error("unmatched frame hit");
   property p_prio;
      (!s_q.tx_busy && s_q.enabled_flag && t_found && !i_wr) |=> s_q.tx_busy
         && s_q.tx_idx == $past(t_idx) && ($past(t_idx) == 4'h0 || !$past(s_q.d[0].armed
         && s_q.d[0].cfg == cmo_pkg::CMO_TX));
   endproperty
   a_prio: assert property (p_prio) else $error("wrong transmit pick");
   property p_tzero;
      $rose(s_q.enabled_flag) |-> s_q.timer == 16'h0000 ##1 s_q.timer == 16'h0000;
   endproperty
   a_tzero: assert property (p_tzero) else $error("timer not from zero");
   property p_ovf;
      (tick && s_q.timer == 16'hFFFF) |=> s_q.ovr && s_q.timer == 16'h0000;
   endproperty
   a_ovf: assert property (p_ovf) else $error("overflow not flagged");
   property p_inc;
      ((i_rd || i_wr) && i_addr == `CMO_A_MSG && !s_q.auto_increment_disable_dis && !i_wr)
         |=> s_q.index == $past(s_q.index) + 3'h1;
   endproperty
   a_inc: assert property (p_inc) else $error("byte index not stepped");
   property p_ttc;
      (s_q.tx_busy && i_tx_err && s_q.ctrl[`CMO_C_TTC])
         |=> !s_q.d[$past(s_q.tx_idx)].armed;
   endproperty
   a_ttc: assert property (p_ttc) else $error("ttc frame retried");
   property p_pg15;
      (i_rd && s_q.page == 4'hF && i_addr >= `CMO_A_CFG) |=> o_rdata == 32'h0000_0000;
   endproperty
   a_pg15: assert property (p_pg15) else $error("page 15 not empty");

endmodule

/* File: cmo_engine_model.sv */
// frame engine stand-in: answers transmit requests and plays received frames
`timescale 1ns/1ps
module cmo_engine_model (
   // clock
   input  wire logic                 i_core_clk,
   // from the manager
   input  wire cmo_pkg::cmo_tx_req_t i_tx,
   // to the manager
   output cmo_pkg::cmo_rx_hdr_t      o_rx_hdr,
   output cmo_pkg::cmo_rx_end_t      o_rx_end,
   output logic                      o_sof,
   output logic                      o_eof,
   output logic                      o_tx_done,
   output logic                      o_tx_err
);
   int          delay = 4;
   int          fail_left = 0;
   logic [31:0] sent_hdr[$];
   logic [63:0] sent_data[$];
   logic        sent_single[$];

   // released fields carry the inverse so stale values never look valid
   task automatic rx_frame(input logic [31:0] hdr, input logic [3:0] dlc,
                           input logic [63:0] data);
      @(posedge i_core_clk);
      o_sof <= 1'b1;
      o_rx_hdr <= {1'b1, hdr};
      @(posedge i_core_clk);
      o_sof <= 1'b0;
      o_rx_hdr <= {1'b0, ~hdr};
      repeat (3) @(posedge i_core_clk);
      o_rx_end <= {2'b10, dlc, data};
      @(posedge i_core_clk);
      o_rx_end <= {2'b00, ~dlc, ~data};
      o_eof <= 1'b1;
      @(posedge i_core_clk);
      o_eof <= 1'b0;
   endtask

   initial
   begin
      o_rx_hdr = '0;
      o_rx_end = '0;
      o_sof = 1'b0;
      o_eof = 1'b0;
      o_tx_done = 1'b0;
      o_tx_err = 1'b0;
      forever
      begin
         @(posedge i_core_clk);
         if (i_tx.valid === 1'b1)
         begin
            sent_hdr.push_back(i_tx.hdr);
            sent_data.push_back(i_tx.data);
            sent_single.push_back(i_tx.single);
            o_sof <= 1'b1;
            @(posedge i_core_clk);
            o_sof <= 1'b0;
            repeat (delay) @(posedge i_core_clk);
            if (fail_left > 0)
            begin
               fail_left--;
               o_tx_err <= 1'b1;
            end
            else
            begin
               o_tx_done <= 1'b1;
               o_eof <= 1'b1;
            end
            @(posedge i_core_clk);
            o_tx_done <= 1'b0;
            o_tx_err <= 1'b0;
            o_eof <= 1'b0;
         end
      end
   end
endmodule

/* File: cmo_manager_bench.sv */
// self-checking bench of the message-object manager
`timescale 1ns/1ps
`include "cmo_consts.svh"
module cmo_manager_bench;
   logic                 clk = 1'b0;
   logic                 rstn = 1'b0;
   logic [3:0]           addr = '0;
   logic [31:0]          wdata = '0;
   logic                 wr_s = 1'b0;
   logic                 rd_s = 1'b0;
   logic [31:0]          rdata;
   cmo_pkg::cmo_rx_hdr_t rx_hdr;
   cmo_pkg::cmo_rx_end_t rx_end;
   cmo_pkg::cmo_tx_req_t tx;
   logic                 sof, eof, tx_done, tx_err, enabled, tovf;
   int                   errors = 0;
   int                   comparisons = 0;
   int                   cycles = 0;

   always #25 clk = ~clk;

   cmo_manager dut_u (.i_core_clk(clk), .i_rstn(rstn), .i_addr(addr), .i_wdata(wdata),
      .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata), .i_rx_hdr(rx_hdr), .i_rx_end(rx_end),
      .i_sof(sof), .i_eof(eof), .i_tx_done(tx_done), .i_tx_err(tx_err), .o_tx(tx),
      .o_enabled(enabled), .o_timer_ovf(tovf));
   cmo_engine_model eng (.i_core_clk(clk), .i_tx(tx), .o_rx_hdr(rx_hdr),
      .o_rx_end(rx_end), .o_sof(sof), .o_eof(eof), .o_tx_done(tx_done), .o_tx_err(tx_err));

   task automatic tally_and_finish;
      $display("comparisons=%0d errors=%0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 8000)
      begin
         errors++;
         tally_and_finish();
      end
   end

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, output logic [31:0] v);
      @(posedge clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      #1 v = rdata;
   endtask

   task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
      logic [31:0] v;
      rd(a, v);
      check(v, exp);
   endtask

   // selects the page with index 0, then tag, mask and configuration
   task automatic desc(input logic [3:0] i, input logic [31:0] tag, mask,
                       input logic [7:0] cfg);
      wr(`CMO_A_PAGE, {24'h0, i, 4'h0});
      wr(`CMO_A_TAG, tag);
      wr(`CMO_A_MASK, mask);
      wr(`CMO_A_CFG, {24'h0, cfg});
   endtask

   task automatic wait_tx(input int n);
      for (int k = 0; k < 300; k++)
      begin
         @(posedge clk);
         if (eng.sent_hdr.size() >= n && tx.valid === 1'b0)
            break;
      end
      check(eng.sent_hdr.size(), n);
   endtask

   task automatic t_reset;
      check(enabled, 0);
      check(tovf, 0);
      rdc(`CMO_A_PAGE, `CMO_PAGE_RST);
      rdc(`CMO_A_TCON, `CMO_TCON_RST);
      rdc(`CMO_A_CFG, 32'h0000_0000);
      for (int i = 0; i < 15; i++)
         desc(i[3:0], 32'h0000_0000, 32'h0000_0000, 8'h00);
      desc(4'hF, 32'h0000_0123, 32'h0000_0000, 8'h40);
      rdc(`CMO_A_TAG, 32'h0000_0000);
      rdc(`CMO_A_CFG, 32'h0000_0000);
      rdc(4'h7, 32'h0000_0000);
      $display("test reset done");
   endtask

   task automatic t_timer;
      logic [31:0] a, b;
      wr(`CMO_A_CTRL, 32'h0000_0001);
      rdc(`CMO_A_TIMER, 32'h0000_0000);
      check(enabled, 1);
      rd(`CMO_A_TIMER, a);
      repeat (78) @(posedge clk);
      rd(`CMO_A_TIMER, b);
      check(16'(b - a), 16'h000A);
      wr(`CMO_A_TCON, 32'h0000_0001);
      wr(`CMO_A_CTRL, 32'h0000_0000);
      repeat (20) @(posedge clk);
      check(enabled, 0);
      rdc(`CMO_A_TIMER, 32'h0000_0000);
      wr(`CMO_A_CTRL, 32'h0000_0001);
      rdc(`CMO_A_TIMER, 32'h0000_0000);
      rd(`CMO_A_TIMER, a);
      repeat (158) @(posedge clk);
      rd(`CMO_A_TIMER, b);
      check(16'(b - a), 16'h000A);
      wr(`CMO_A_TCON, 32'h0000_0000);
      $display("test timer done");
   endtask

   task automatic t_tx;
      logic [31:0] s2, s5;
      wr(`CMO_A_CTRL, 32'h0000_0000);
      desc(4'h5, 32'h2000_0055, 32'h0000_0000, 8'h41);
      desc(4'h2, 32'h0000_0022, 32'h0000_0000, 8'h48);
      for (int k = 0; k < 9; k++)
         wr(`CMO_A_MSG, 32'h10 + k);
      wr(`CMO_A_PAGE, 32'h0000_002B);
      rdc(`CMO_A_MSG, 32'h0000_0013);
      rdc(`CMO_A_MSG, 32'h0000_0013);
      eng.fail_left = 1;
      eng.delay = 20;
      wr(`CMO_A_CTRL, 32'h0000_0001);
      wait_tx(3);
      check(eng.sent_hdr[0], 32'h0000_0022);
      check(eng.sent_hdr[1], 32'h0000_0022);
      check(eng.sent_hdr[2], 32'h2000_0055);
      check(eng.sent_data[0], 64'h1716_1514_1312_1118);
      check(eng.sent_single[0], 0);
      wr(`CMO_A_PAGE, 32'h0000_0020);
      rdc(`CMO_A_FLAGS, 32'h0000_0002);
      rdc(`CMO_A_TAG, 32'h0000_0022);
      rd(`CMO_A_STAMP, s2);
      wr(`CMO_A_PAGE, 32'h0000_0050);
      rdc(`CMO_A_FLAGS, 32'h0000_0002);
      rd(`CMO_A_STAMP, s5);
      check(s5 > s2, 1);
      eng.delay = 4;
      $display("test transmit done");
   endtask

   task automatic t_rx;
      desc(4'h3, 32'h0000_0310, 32'hE000_07F8, 8'h80);
      desc(4'h1, 32'h0000_0317, 32'hE000_07FF, 8'h80);
      eng.rx_frame(32'h0000_0317, 4'h8, 64'hA8A7_A6A5_A4A3_A2A1);
      eng.rx_frame(32'h0000_0312, 4'h3, 64'h0000_0000_00B3_B2B1);
      eng.rx_frame(32'h0000_0400, 4'h5, 64'hC5C4_C3C2_C1C0_CFCE);
      wr(`CMO_A_PAGE, 32'h0000_0010);
      rdc(`CMO_A_FLAGS, 32'h0000_0001);
      rdc(`CMO_A_CFG, 32'h0000_0088);
      rdc(`CMO_A_MSG, 32'h0000_00A1);
      rdc(`CMO_A_MSG, 32'h0000_00A2);
      wr(`CMO_A_PAGE, 32'h0000_0030);
      rdc(`CMO_A_FLAGS, 32'h0000_0001);
      rdc(`CMO_A_TAG, 32'h0000_0312);
      rdc(`CMO_A_CFG, 32'h0000_0083);
      rdc(`CMO_A_MSG, 32'h0000_00B1);
      $display("test receive done");
   endtask

   task automatic t_reply;
      logic [31:0] v;
      desc(4'h6, 32'h2000_0066, 32'hE000_07FF, 8'hA2);
      wr(`CMO_A_MSG, 32'h0000_0061);
      wr(`CMO_A_MSG, 32'h0000_0062);
      eng.rx_frame(32'h2000_0066, 4'h2, 64'hEEEE_EEEE_EEEE_EEEE);
      wait_tx(4);
      check(eng.sent_hdr[3], 32'h0000_0066);
      check(eng.sent_data[3][15:0], 16'h6261);
      rd(`CMO_A_FLAGS, v);
      check(v[1:0], 2'b10);
      rd(`CMO_A_CFG, v);
      check(v[5], 0);
      $display("test reply done");
   endtask

   task automatic t_fbuf;
      logic [31:0] v;
      desc(4'h7, 32'h0000_0070, 32'hE000_07FF, 8'hC0);
      desc(4'h9, 32'h0000_0090, 32'hE000_07FF, 8'hC0);
      eng.rx_frame(32'h0000_0070, 4'h1, 64'h0000_0000_0000_0007);
      rd(`CMO_A_STATUS, v);
      check(v[2], 0);
      eng.rx_frame(32'h0000_0090, 4'h1, 64'h0000_0000_0000_0009);
      rd(`CMO_A_STATUS, v);
      check(v[2], 1);
      wr(`CMO_A_STATUS, 32'h0000_0004);
      rd(`CMO_A_STATUS, v);
      check(v[2], 1);
      wr(`CMO_A_PAGE, 32'h0000_0070);
      wr(`CMO_A_CFG, 32'h0000_00C0);
      wr(`CMO_A_PAGE, 32'h0000_0090);
      wr(`CMO_A_CFG, 32'h0000_00C0);
      wr(`CMO_A_STATUS, 32'h0000_0004);
      rd(`CMO_A_STATUS, v);
      check(v[2], 0);
      wr(`CMO_A_CTRL, 32'h0000_0019);
      rdc(`CMO_A_HPOBJ, 32'h0000_0010);
      wr(`CMO_A_PAGE, 32'h0000_0010);
      wr(`CMO_A_FLAGS, 32'h0000_0000);
      rdc(`CMO_A_HPOBJ, 32'h0000_0020);
      $display("test buffer set done");
   endtask

   task automatic t_ttc;
      logic [31:0] c1, c2;
      wr(`CMO_A_CTRL, 32'h0000_0003);
      eng.fail_left = 1;
      desc(4'h8, 32'h0000_0088, 32'h0000_0000, 8'h40);
      wait_tx(5);
      repeat (30) @(posedge clk);
      check(eng.sent_hdr.size(), 5);
      check(eng.sent_single[4], 1);
      rdc(`CMO_A_FLAGS, 32'h0000_0000);
      rd(`CMO_A_TTCAP, c1);
      wr(`CMO_A_CTRL, 32'h0000_0007);
      eng.rx_frame(32'h0000_0400, 4'h0, 64'h0000_0000_0000_0000);
      rd(`CMO_A_TTCAP, c2);
      check(c2 > c1, 1);
      $display("test time trigger done");
   endtask

   initial
   begin
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      t_reset();
      t_timer();
      t_tx();
      t_rx();
      t_reply();
      t_fbuf();
      t_ttc();
      tally_and_finish();
   end
endmodule
